// ### rtl/mtc_regs.vh
`ifndef MTC_REGS_VH
`define MTC_REGS_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define MTC_CLK_HZ        100000000
`define MTC_INC_RATE_HZ   1000
`define MTC_FAST_RATE_HZ  2200
`define MTC_INC_TICKS     (`MTC_CLK_HZ / `MTC_INC_RATE_HZ)
`define MTC_FAST_TICKS    (`MTC_CLK_HZ / `MTC_FAST_RATE_HZ)
`define MTC_SETTLE_MS     10
`define MTC_SETTLE_TICKS  (`MTC_CLK_HZ / 1000 * `MTC_SETTLE_MS)
`define MTC_MARK_CYCLES   4
// ----------------------------------------
// character layout
// ----------------------------------------
`define MTC_CHAR_BITS     8
`define MTC_CNT_W         4
`define MTC_CNT_RESET     4'h0
`endif

// ### rtl/mtc_fifo.v
`timescale 1ns/1ns
// ----------------------------------------
// simple synchronous fifo
// ----------------------------------------
module mtc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clock,
  input  wire             reset,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
                     (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // mtc_fifo

// ### rtl/mtc_codec.v
// How it works
// RULE1: write a zero bit as a mark on track zero, one on track one
// RULE2: read side ORs both track marks into the bit strobe; the code gives no strobe when both marks rise in the same cycle
// RULE3: playback_data flop set by track one mark, cleared by track zero
// RULE4: each bit strobe shifts playback_data into the character buffer
// RULE5: every written character starts with marks on both tracks
// RULE6: read side ANDs the tracks; both at once gives char_start_pulse
// RULE7: char_start_pulse starts the bit counting for that character
// RULE8: incremental writing runs at 1000 bits per second
// RULE9: wait 10 ms after motor start before the first mark
// RULE10: eight bit character buffer, parallel load or serial capture
// RULE11: four bit down counter times a character; end gives ready strobe
// RULE12: write clock 1000 Hz, or 2200 Hz at the fast character rate
// RULE13: one pulse per mark per write tick, none between characters
`timescale 1ns/1ns
`include "mtc_regs.vh"
module mtc_codec #(
  parameter SETTLE_TICKS = `MTC_SETTLE_TICKS,
  parameter INC_TICKS    = `MTC_INC_TICKS,
  parameter FAST_TICKS   = `MTC_FAST_TICKS,
  parameter FIFO_DEPTH   = 16
) (
  input  wire       clock,
  input  wire       reset,
  input  wire       write_mode,
  input  wire       fast_rate,
  input  wire [7:0] wr_data,
  input  wire       wr_valid,
  output wire       wr_ready,
  output reg        motor_run,
  output reg        mark_zero,
  output reg        mark_one,
  input  wire       track_zero,
  input  wire       track_one,
  output reg        playback_data,
  output reg        char_start_pulse,
  output reg  [7:0] rd_data,
  output reg        char_ready_strobe,
  output wire       rd_valid,
  input  wire       rd_ready
);
  // ----------------------------------------
  // write side
  // ----------------------------------------
  localparam W_IDLE   = 3'h0;
  localparam W_SETTLE = 3'h1;
  localparam W_START  = 3'h2;
  localparam W_BITS   = 3'h3;
  localparam W_STOP   = 3'h4;

  // ----------------------------------------
  // sized constants
  // ----------------------------------------
  localparam [2:0]            MARK_LAST = `MTC_MARK_CYCLES - 1;
  localparam [`MTC_CNT_W-1:0] CHAR_BITS = `MTC_CHAR_BITS;

  wire [7:0] fifo_data;
  wire       fifo_valid;
  reg        fifo_pop;
  reg  [2:0] wstate;
  reg  [31:0] tick_cnt;
  reg  [31:0] settle_cnt;
  reg  [7:0] wshift;
  reg  [`MTC_CNT_W-1:0] wcount;
  reg  [2:0] pulse_cnt;
  wire       tick;
  wire [31:0] tick_period;

  // ----------------------------------------
  // character fifo
  // ----------------------------------------
  mtc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_data   (wr_data),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ----------------------------------------
  // bit tick timer
  // ----------------------------------------
  // rate picked per tick, so a rate change lands on the next bit
  assign tick_period = fast_rate ? FAST_TICKS : INC_TICKS; // see RULE12
  assign tick = (tick_cnt == 32'h0);

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      tick_cnt <= 32'h0;
    end else if (tick || wstate == W_IDLE) begin
      tick_cnt <= tick_period - 32'h1; // see RULE8
    end else begin
      tick_cnt <= tick_cnt - 32'h1;
    end
  end

  // ----------------------------------------
  // write sequencer
  // ----------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wstate     <= W_IDLE;
      settle_cnt <= 32'h0;
      wshift     <= 8'h00;
      wcount     <= `MTC_CNT_RESET;
      motor_run  <= 1'b0;
      mark_zero  <= 1'b0;
      mark_one   <= 1'b0;
      pulse_cnt  <= 3'h0;
      fifo_pop   <= 1'b0;
    end else begin
      fifo_pop <= 1'b0;
      if (pulse_cnt != 3'h0) begin
        pulse_cnt <= pulse_cnt - 3'h1;
      end else begin
        mark_zero <= 1'b0; // see RULE13
        mark_one  <= 1'b0;
      end
      case (wstate)
        W_IDLE: begin
          motor_run <= 1'b0;
          if (write_mode && fifo_valid) begin
            wshift     <= fifo_data; // see RULE10
            fifo_pop   <= 1'b1;
            motor_run  <= 1'b1;
            settle_cnt <= SETTLE_TICKS - 1;
            wstate     <= W_SETTLE;
          end
        end
        W_SETTLE: begin
          if (settle_cnt == 32'h0) begin
            wstate <= W_START; // see RULE9
          end else begin
            settle_cnt <= settle_cnt - 32'h1;
          end
        end
        W_START: begin
          if (tick) begin
            mark_zero <= 1'b1; // see RULE5
            mark_one  <= 1'b1;
            pulse_cnt <= MARK_LAST;
            wcount    <= CHAR_BITS;
            wstate    <= W_BITS;
          end
        end
        W_BITS: begin
          if (tick) begin
            mark_zero <= ~wshift[0]; // see RULE1
            mark_one  <= wshift[0];
            pulse_cnt <= MARK_LAST;
            wshift    <= {1'b0, wshift[7:1]};
            wcount    <= wcount - 4'h1;
            if (wcount == 4'h1) begin
              wstate <= W_STOP;
            end
          end
        end
        W_STOP: begin
          if (tick) begin
            // back to back characters skip the motor settle
            if (write_mode && fifo_valid) begin
              wshift   <= fifo_data;
              fifo_pop <= 1'b1;
              wstate   <= W_START;
            end else begin
              wstate <= W_IDLE;
            end
          end
        end
        default: begin
          wstate <= W_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read side
  // ----------------------------------------
  reg  [1:0] sz;
  reg  [1:0] so;
  reg        z_d;
  reg        o_d;
  reg        rd_busy;
  reg  [`MTC_CNT_W-1:0] rcount;
  reg  [7:0] rshift;
  reg        rd_full;
  wire       z_rise;
  wire       o_rise;
  wire       both;
  wire       strobe;
  wire       char_done;

  // ----------------------------------------
  // track synchronisers
  // ----------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sz  <= 2'h0;
      so  <= 2'h0;
      z_d <= 1'b0;
      o_d <= 1'b0;
    end else begin
      sz  <= {sz[0], track_zero};
      so  <= {so[0], track_one};
      z_d <= sz[1];
      o_d <= so[1];
    end
  end

  // ----------------------------------------
  // mark edges
  // ----------------------------------------
  // coincidence judged on the same sample; skewed tracks miss the start
  assign z_rise = sz[1] && !z_d;
  assign o_rise = so[1] && !o_d;
  assign both   = z_rise && o_rise;            // see RULE6
  assign strobe = (z_rise || o_rise) && !both; // see RULE2
  assign rd_valid = rd_full;

  // ----------------------------------------
  // playback data flop and start pulse
  // ----------------------------------------
  reg        strobe_d;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      playback_data    <= 1'b0;
      char_start_pulse <= 1'b0;
      strobe_d         <= 1'b0;
    end else begin
      char_start_pulse <= both;
      // buffer shifts the flop output, so it waits one cycle for it
      strobe_d         <= strobe;
      if (o_rise && !z_rise) begin
        playback_data <= 1'b1; // see RULE3
      end else if (z_rise && !o_rise) begin
        playback_data <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // character buffer and bit counter
  // ----------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_busy <= 1'b0;
      rcount  <= `MTC_CNT_RESET;
      rshift  <= 8'h00;
    end else begin
      if (write_mode) begin
        rd_busy <= 1'b0;
      end else if (both) begin
        rd_busy <= 1'b1; // see RULE7
        rcount  <= CHAR_BITS; // see RULE11
      end else if (strobe_d && rd_busy) begin
        rshift <= {playback_data, rshift[7:1]}; // see RULE4
        rcount <= rcount - 4'h1;
        if (rcount == 4'h1) begin
          rd_busy <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // parallel hand-off to the host
  // ----------------------------------------
  assign char_done = !write_mode && !both && strobe_d && rd_busy &&
                     (rcount == 4'h1);

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_data           <= 8'h00;
      rd_full           <= 1'b0;
      char_ready_strobe <= 1'b0;
    end else begin
      char_ready_strobe <= char_done; // see RULE11
      if (char_done) begin
        rd_data <= {playback_data, rshift[7:1]};
        rd_full <= 1'b1;
      end else if (rd_full && rd_ready) begin
        // a new character wins over a same-cycle read
        rd_full <= 1'b0;
      end
    end
  end
endmodule // mtc_codec

// ### dv/mtc_codec_properties.sv
`timescale 1ns/1ns
module mtc_codec_properties (
  input wire clock,
  input wire reset,
  input wire write_mode,
  input wire motor_run,
  input wire mark_zero,
  input wire mark_one,
  input wire track_zero,
  input wire track_one,
  input wire playback_data,
  input wire char_start_pulse,
  input wire char_ready_strobe,
  input wire rd_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence pulse4(s); s[*4] ##1 !s; endsequence
  sequence lone(a, b); $rose(a) && !b && !write_mode; endsequence
  one_pulse_a: assert property ($rose(mark_one) |-> pulse4(mark_one))
    else $error("mark_one width wrong");
  zero_pulse_a: assert property ($rose(mark_zero) |-> pulse4(mark_zero))
    else $error("mark_zero width wrong");
  marks_motor_a: assert property ((mark_zero || mark_one) |-> motor_run)
    else $error("mark without motor");
  settle_quiet_a: assert property ($rose(motor_run) |-> (!(mark_zero || mark_one))[*8])
    else $error("mark before settle");
  start_det_a: assert property ($rose(track_zero) && $rose(track_one) && !write_mode
    |-> ##[3:5] char_start_pulse)
    else $error("start pulse missing");
  lone_mark_a: assert property (lone(track_one, track_zero) |-> ##4 !char_start_pulse)
    else $error("start pulse on one track");
  pd_set_a: assert property (lone(track_one, track_zero) |-> ##[2:6] playback_data)
    else $error("playback data not set");
  pd_clear_a: assert property (lone(track_zero, track_one) |-> ##[2:6] !playback_data)
    else $error("playback data not cleared");
  ready_valid_a: assert property ($rose(char_ready_strobe) |-> ##[0:1] rd_valid)
    else $error("ready without valid");
endmodule // mtc_codec_properties
bind mtc_codec mtc_codec_properties mtc_codec_properties_inst (.clock(clock),
  .reset(reset), .write_mode(write_mode), .motor_run(motor_run),
  .mark_zero(mark_zero), .mark_one(mark_one), .track_zero(track_zero),
  .track_one(track_one), .playback_data(playback_data),
  .char_start_pulse(char_start_pulse), .char_ready_strobe(char_ready_strobe),
  .rd_valid(rd_valid));

// ### dv/mtc_tape_model.sv
`timescale 1ns/1ns
module mtc_tape_model (
  input  wire clock,
  input  wire motor_run,
  input  wire mark_zero,
  input  wire mark_one,
  output reg  track_zero,
  output reg  track_one
);
  reg       prev = 1'b0;
  reg [3:0] cnt = 4'h8;
  reg [7:0] bits, last_char;
  integer   n_chars = 0, gap = 0, since = 0, idle = 0, settle = 0;
  initial begin
    track_zero = 1'b0;
    track_one = 1'b0;
  end
  // ---------
  // tape image of written marks
  // ---------
  always @(posedge clock) begin
    since = since + 1;
    idle = motor_run ? idle + 1 : 0;
    if ((mark_zero || mark_one) && !prev) begin
      gap = since;
      since = 0;
      if (mark_zero && mark_one) begin
        settle = idle;
        cnt = 4'h0;
      end else if (cnt < 4'h8) begin
        bits[cnt] = mark_one;
        cnt = cnt + 4'h1;
        if (cnt == 4'h8) begin
          last_char = bits;
          n_chars = n_chars + 1;
        end
      end
    end
    prev = mark_zero || mark_one;
  end
  // ---------
  // playback, off the codec clock phase
  // ---------
  task mark(input z, input o);
    begin
      track_zero = z;
      track_one = o;
      #62;
      track_zero = 1'b0;
      track_one = 1'b0;
      #63;
    end
  endtask
  task play(input [7:0] c);
    integer i;
    begin
      #1;
      mark(1'b1, 1'b1);
      for (i = 0; i < 8; i = i + 1) mark(!c[i], c[i]);
    end
  endtask
endmodule // mtc_tape_model

// ### dv/tb_mtc_codec.sv
`timescale 1ns/1ns
module tb_mtc_codec;
  reg        clock, reset, write_mode, fast_rate, wr_valid, rd_ready;
  reg  [7:0] wr_data;
  wire       wr_ready, motor_run, mark_zero, mark_one, track_zero, track_one;
  wire       playback_data, char_start_pulse, char_ready_strobe, rd_valid;
  wire [7:0] rd_data;
  integer    n_errors = 0, compares = 0, n_ready = 0, i, k, n0;
  mtc_codec #(.SETTLE_TICKS(50), .INC_TICKS(20), .FAST_TICKS(9)) mtc_codec_inst (
    .clock(clock), .reset(reset), .write_mode(write_mode),
    .fast_rate(fast_rate), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .motor_run(motor_run), .mark_zero(mark_zero),
    .mark_one(mark_one), .track_zero(track_zero), .track_one(track_one),
    .playback_data(playback_data), .char_start_pulse(char_start_pulse),
    .rd_data(rd_data), .char_ready_strobe(char_ready_strobe),
    .rd_valid(rd_valid), .rd_ready(rd_ready));
  mtc_tape_model mtc_tape_model_inst (.clock(clock), .motor_run(motor_run),
    .mark_zero(mark_zero), .mark_one(mark_one),
    .track_zero(track_zero), .track_one(track_one));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (char_ready_strobe) n_ready <= n_ready + 1;
  task check(input string what, input [31:0] exp, input [31:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  task final_report;
    begin
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task push(input [7:0] d);
    begin
      @(negedge clock);
      wr_data = d;
      wr_valid = 1'b1;
      while (wr_ready !== 1'b1) @(negedge clock);
      @(negedge clock);
      wr_valid = 1'b0;
    end
  endtask
  task wait_chars(input integer n);
    begin
      k = 0;
      while (mtc_tape_model_inst.n_chars < n && k < 20000) begin
        @(negedge clock);
        k = k + 1;
      end
    end
  endtask
  task t_write(input fast, input [7:0] d, input integer tick);
    begin
      fast_rate = fast;
      n0 = mtc_tape_model_inst.n_chars;
      push(d);
      wait_chars(n0 + 1);
      check("char", d, mtc_tape_model_inst.last_char);
      check("settle", 1, mtc_tape_model_inst.settle >= 50);
      check("tick", tick, mtc_tape_model_inst.gap);
    end
  endtask
  task t_fill;
    begin
      n0 = mtc_tape_model_inst.n_chars;
      i = 0;
      @(negedge clock);
      while (wr_ready && i < 40) begin
        wr_data = i[7:0];
        wr_valid = 1'b1;
        @(negedge clock);
        i = i + 1;
      end
      wr_valid = 1'b0;
      check("fill", 1, i >= 16 && i < 40);
      wait_chars(n0 + i);
      check("drain", i - 1, mtc_tape_model_inst.last_char);
    end
  endtask
  task t_read(input [7:0] c);
    begin
      n0 = n_ready;
      mtc_tape_model_inst.play(c);
      k = 0;
      while (rd_valid !== 1'b1 && k < 200) begin
        @(negedge clock);
        k = k + 1;
      end
      check("rd_data", c, rd_data);
      check("playback_data", c[7], playback_data);
      check("ready", n0 + 1, n_ready);
      rd_ready = 1'b1;
      @(negedge clock);
      rd_ready = 1'b0;
    end
  endtask
  initial begin
    #900000;
    n_errors = n_errors + 1;
    final_report;
  end
  initial begin
    reset = 1'b1;
    write_mode = 1'b1;
    fast_rate = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    rd_ready = 1'b0;
    repeat (16) @(negedge clock);
    reset = 1'b0;
    t_write(1'b0, 8'hA5, 20);
    t_write(1'b1, 8'h3C, 9);
    t_fill;
    repeat (40) @(negedge clock);
    write_mode = 1'b0;
    t_read(8'h5A);
    t_read(8'hC3);
    final_report;
  end
endmodule // tb_mtc_codec
